// *** verilog/tsc_consts.vh ***
// Summary of operation
// - Overflow flag sets when the counter passes the modulo value in up counting, or leaves zero counting down in up-down counting.
// - Flag clears only after a read with flag set, then writing zero.
// - Writing one to the overflow flag leaves it unchanged but cancels a pending clear.
// - Overflow between qualifying read and clearing write cancels the clear.
// - Bit 6 enables the overflow interrupt while the flag is set.
// - Bit 5 selects up counting or up-down counting.
// - Mode, clock source and prescale bits writable only with protect disabled.
// - Clock source 00 selects no clock; counter stops.
// - Source 01 is system clock halved, or undivided with extended features.
// - Source 10 is the fixed frequency clock, 11 the external clock.
// - Prescale divides the selected clock by two to the field value.
// - New prescale takes effect one system clock after the register update.
// - Any write to the status register restarts counter read coherency.
`ifndef TSC_CONSTS_VH
`define TSC_CONSTS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define TSC_ADDR_SC 12'h000
`define TSC_ADDR_CFG 12'h004
`define TSC_ADDR_CNT 12'h008
`define TSC_ADDR_MOD 12'h00C
`define TSC_ADDR_IST 12'h010
`define TSC_ADDR_IMSK 12'h014
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TSC_SC_TOF 7
`define TSC_SC_OVERFLOW_IRQ_ENABLE 6
`define TSC_SC_CENTER_PWM_SELECT 5
`define TSC_SC_CLOCK_SOURCE_SELECT_HI 4
`define TSC_SC_CLOCK_SOURCE_SELECT_LO 3
`define TSC_SC_PS_HI 2
`define TSC_SC_PS_LO 0
`define TSC_CFG_WRITE_PROTECT_DISABLE 0
`define TSC_CFG_FEN 1
`define TSC_IST_OVF 0
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define TSC_SC_RESET 8'h00
`define TSC_CFG_RESET 2'h0
`define TSC_CLK_NONE 2'h0
`define TSC_CLK_SYS 2'h1
`define TSC_CLK_FIX 2'h2
`define TSC_CLK_EXT 2'h3
`endif

// *** verilog/tsc_clk_sel.v ***
`include "tsc_consts.vh"
module tsc_clk_sel (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Selection
  input wire [1:0] clk_src,
  input wire ext_features,
  // Source ticks
  input wire fixed_tick,
  input wire ext_tick,
  // Result
  output reg src_tick
);
  reg half_r;

  // ----------------------------------------
  // Source multiplexer
  // ----------------------------------------
  // Half-rate toggle for the halved system clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
    end
  end

  always @* begin
    case (clk_src)
      `TSC_CLK_NONE: src_tick = 1'b0;
      `TSC_CLK_SYS: src_tick = ext_features ? 1'b1 : half_r;
      `TSC_CLK_FIX: src_tick = fixed_tick;
      `TSC_CLK_EXT: src_tick = ext_tick;
      default: src_tick = 1'b0;
    endcase
  end
endmodule

// *** verilog/tsc_prescaler.v ***
`include "tsc_consts.vh"
module tsc_prescaler (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire [2:0] ps,
  input wire src_tick,
  // Result
  output wire cnt_tick
);
  reg [6:0] div_r;
  reg [2:0] ps_r;
  wire [6:0] mask;

  // ----------------------------------------
  // Power-of-two divider
  // ----------------------------------------
  // Field is sampled one cycle late so a new value acts on the next clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_r <= 3'h0;
      div_r <= 7'h00;
    end else begin
      ps_r <= ps;
      if (src_tick) begin
        div_r <= cnt_tick ? 7'h00 : div_r + 7'h01;
      end
    end
  end

  assign mask = (7'h01 << ps_r) - 7'h01;
  assign cnt_tick = src_tick && ((div_r & mask) == mask);
endmodule

// *** verilog/tsc_top.v ***
`include "tsc_consts.vh"
module tsc_top (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Clock source ticks
  input wire fixed_tick,
  input wire ext_tick,
  // Timer outputs
  output reg ovf_irq,
  output reg irq,
  output reg up_down_mode,
  output reg coherency_restart
);
  reg tof_r;
  reg overflow_irq_enable_r;
  reg center_pwm_select_r;
  reg [1:0] clock_source_select_r;
  reg [2:0] ps_r;
  reg write_protect_disable_r;
  reg fen_r;
  reg [15:0] cnt_r;
  reg [15:0] mod_r;
  reg dir_down_r;
  reg armed_r;
  reg ist_r;
  reg imsk_r;
  reg [31:0] rd_nxt;
  reg err_nxt;
  wire src_tick;
  wire cnt_tick;
  wire acc;
  wire wr;
  wire rd;
  wire ovf;
  wire [7:0] sc_val;

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  tsc_clk_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .clk_src(clock_source_select_r),
    .ext_features(fen_r),
    .fixed_tick(fixed_tick),
    .ext_tick(ext_tick),
    .src_tick(src_tick)
  );

  tsc_prescaler u_ps (
    .pclk(pclk),
    .presetn(presetn),
    .ps(ps_r),
    .src_tick(src_tick),
    .cnt_tick(cnt_tick)
  );

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Zero wait state: pready held high, access completes in one phase
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign sc_val = {tof_r, overflow_irq_enable_r, center_pwm_select_r, clock_source_select_r, ps_r};

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Overflow event when the counter passes the modulo value counting up, or leaves zero counting down in up-down mode
  assign ovf = cnt_tick &&
    (center_pwm_select_r ? (dir_down_r && cnt_r == 16'h0000) : (cnt_r == mod_r));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      dir_down_r <= 1'b0;
    end else if (wr && paddr == `TSC_ADDR_CNT) begin
      cnt_r <= 16'h0000;
      dir_down_r <= 1'b0;
    end else if (cnt_tick) begin
      if (!center_pwm_select_r) begin
        cnt_r <= (cnt_r == mod_r) ? 16'h0000 : cnt_r + 16'h0001;
        dir_down_r <= 1'b0;
      end else if (!dir_down_r) begin
        if (cnt_r >= mod_r) begin
          dir_down_r <= 1'b1;
          cnt_r <= cnt_r - 16'h0001;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end else begin
        if (cnt_r == 16'h0000) begin
          dir_down_r <= 1'b0;
          cnt_r <= 16'h0001;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Status and control register
  // ----------------------------------------
  // A read with the flag set arms the clear; a new overflow disarms it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tof_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
      center_pwm_select_r <= 1'b0;
      clock_source_select_r <= `TSC_CLK_NONE;
      ps_r <= 3'h0;
      armed_r <= 1'b0;
      write_protect_disable_r <= 1'b0;
      fen_r <= 1'b0;
      mod_r <= 16'hFFFF;
    end else begin
      if (ovf) begin
        tof_r <= 1'b1;
        armed_r <= 1'b0;
      end else if (rd && paddr == `TSC_ADDR_SC && tof_r) begin
        armed_r <= 1'b1;
      end else if (wr && paddr == `TSC_ADDR_SC) begin
        // Writing one leaves the flag alone; zero clears only when armed
        if (!pwdata[`TSC_SC_TOF] && armed_r) begin
          tof_r <= 1'b0;
        end
        armed_r <= 1'b0;
      end
      if (wr && paddr == `TSC_ADDR_SC) begin
        overflow_irq_enable_r <= pwdata[`TSC_SC_OVERFLOW_IRQ_ENABLE];
        if (write_protect_disable_r) begin
          center_pwm_select_r <= pwdata[`TSC_SC_CENTER_PWM_SELECT];
          clock_source_select_r <= pwdata[`TSC_SC_CLOCK_SOURCE_SELECT_HI:`TSC_SC_CLOCK_SOURCE_SELECT_LO];
          ps_r <= pwdata[`TSC_SC_PS_HI:`TSC_SC_PS_LO];
        end
      end
      if (wr && paddr == `TSC_ADDR_CFG) begin
        write_protect_disable_r <= pwdata[`TSC_CFG_WRITE_PROTECT_DISABLE];
        fen_r <= pwdata[`TSC_CFG_FEN];
      end
      if (wr && paddr == `TSC_ADDR_MOD) begin
        mod_r <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Set wins over a write-one clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 1'b0;
      imsk_r <= 1'b0;
    end else begin
      if (ovf) begin
        ist_r <= 1'b1;
      end else if (wr && paddr == `TSC_ADDR_IST && pwdata[`TSC_IST_OVF]) begin
        ist_r <= 1'b0;
      end
      if (wr && paddr == `TSC_ADDR_IMSK) begin
        imsk_r <= pwdata[`TSC_IST_OVF];
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rd_nxt = 32'h00000000;
    err_nxt = 1'b0;
    case (paddr)
      `TSC_ADDR_SC: rd_nxt = {24'h000000, sc_val};
      `TSC_ADDR_CFG: rd_nxt = {30'h00000000, fen_r, write_protect_disable_r};
      `TSC_ADDR_CNT: rd_nxt = {16'h0000, cnt_r};
      `TSC_ADDR_MOD: rd_nxt = {16'h0000, mod_r};
      `TSC_ADDR_IST: rd_nxt = {31'h00000000, ist_r};
      `TSC_ADDR_IMSK: rd_nxt = {31'h00000000, imsk_r};
      default: err_nxt = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  // Outputs lag their sources by one cycle, kept registered for timing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ovf_irq <= 1'b0;
      irq <= 1'b0;
      up_down_mode <= 1'b0;
      coherency_restart <= 1'b0;
    end else begin
      pready <= 1'b1;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : prdata;
      pslverr <= psel && !penable && err_nxt;
      ovf_irq <= tof_r && overflow_irq_enable_r;
      irq <= ist_r && imsk_r;
      up_down_mode <= center_pwm_select_r;
      coherency_restart <= wr && paddr == `TSC_ADDR_SC;
    end
  end
endmodule

// *** testbench/tsc_props.sv ***
module tsc_props (
  // Bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Outputs
  input wire ovf_irq,
  input wire up_down_mode,
  input wire coherency_restart
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire wsc = wr && paddr == 12'h000;
  reg wp_r;
  reg ien_r;
  // Shadow of protect and enable bits, so checks need no internals
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= 1'b0;
      ien_r <= 1'b0;
    end else begin
      if (wr && paddr == 12'h004) wp_r <= pwdata[0];
      if (wsc) ien_r <= pwdata[6];
    end
  end
  a_restart_after_wr: assert property (wsc |=> coherency_restart)
    else $error("no restart");
  a_restart_cause: assert property (coherency_restart |-> $past(wsc))
    else $error("stray restart");
  a_mode_write: assert property (wsc && wp_r |=> ##1 up_down_mode == $past(pwdata[5], 2))
    else $error("mode not written");
  a_mode_protect: assert property (wsc && !wp_r |=> ##1 $stable(up_down_mode))
    else $error("mode not protected");
  a_mode_cause: assert property ($changed(up_down_mode) |-> $past(wsc, 2))
    else $error("stray mode change");
  a_irq_needs_en: assert property (ovf_irq |-> $past(ien_r))
    else $error("irq while disabled");
  a_irq_drop_cause: assert property ($fell(ovf_irq) |-> $past(wsc, 2))
    else $error("irq dropped alone");
  a_tof_one_kept: assert property (wsc && pwdata[7:6] == 2'h3 && ien_r && ovf_irq
    && !$past(wsc) |=> ##1 ovf_irq)
    else $error("flag lost on one");
endmodule

// *** testbench/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg fixed_tick = 0, ext_tick = 0, ext_on = 0, err = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd = 0, v = 0;
  reg [15:0] c0 = 0;
  reg [2:0] cyc = 0;
  wire [31:0] prdata;
  wire pready, pslverr, ovf_irq, irq, up_down_mode, coherency_restart;
  integer err_count = 0, comparisons = 0, seed = 32'h55EF4CCE, i;
  tsc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fixed_tick, .ext_tick, .ovf_irq, .irq, .up_down_mode,
    .coherency_restart);
  // -----
  // Clock and source ticks
  // -----
  always #5 pclk = ~pclk;
  // Fixed tick every 4 cycles; external every 8 only while enabled
  always @(posedge pclk) begin
    cyc <= cyc + 3'h1;
    fixed_tick <= cyc[1:0] == 2'h0;
    ext_tick <= ext_on && cyc == 3'h3;
  end
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  // One transfer; data and error taken at the pready edge
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counter advance over 1024 cycles, a whole number of the slowest tick period
  function [15:0] rate(input [1:0] s, input f, input [2:0] p);
    case (s)
      2'h0: rate = 16'h0;
      2'h1: rate = 16'h400 >> ({1'b0, p} + !f);
      2'h2: rate = 16'h100 >> p;
      default: rate = 16'h80 >> p;
    endcase
  endfunction
  task stop_test;
    $display("Checks %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0);
    chk(rd, 32'h0, "sc reset");
    apb(1, 12'h000, 32'h7F);
    apb(0, 12'h000, 0);
    chk(rd, 32'h40, "sc protected");
    chk(up_down_mode, 0, "mode locked");
    apb(0, 12'h020, 0);
    chk(err, 1, "unmapped");
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h000, 32'h20);
    @(posedge pclk);
    #1 chk(up_down_mode, 1, "mode");
    $display("End protect test");
    ext_on <= 1'b1;
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      if (i < 4) v[4:0] = {i[1:0], 3'h7};
      apb(1, 12'h004, {v[8], 1'b1});
      apb(1, 12'h000, v[4:0]);
      apb(0, 12'h000, 0);
      chk(rd, v[4:0], "fields");
      apb(0, 12'h008, 0);
      c0 = rd[15:0];
      repeat (1021) @(posedge pclk);
      apb(0, 12'h008, 0);
      c0 = rd[15:0] - c0;
      chk(c0, rate(v[4:3], v[8], v[2:0]), "rate");
    end
    $display("End rate test");
    ext_on <= 1'b0;
    apb(1, 12'h004, 32'h3);
    apb(1, 12'h00C, 32'h2);
    apb(1, 12'h008, 0);
    apb(1, 12'h000, 32'h58);
    ext_on <= 1'b1;
    repeat (64) @(posedge pclk);
    ext_on <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(0, 12'h000, 0);
    chk(rd[7], 1, "flag set");
    chk(ovf_irq, 1, "ovf irq");
    apb(0, 12'h010, 0);
    chk(rd, 1, "status");
    chk(irq, 0, "masked");
    apb(1, 12'h014, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 1, "unmasked");
    apb(1, 12'h010, 1);
    repeat (2) @(posedge pclk);
    chk(irq, 0, "status clear");
    apb(1, 12'h000, 32'hD8);
    apb(1, 12'h000, 32'h58);
    apb(0, 12'h000, 0);
    chk(rd[7], 1, "no read");
    ext_on <= 1'b1;
    repeat (32) @(posedge pclk);
    ext_on <= 1'b0;
    repeat (8) @(posedge pclk);
    apb(1, 12'h000, 32'h58);
    apb(0, 12'h000, 0);
    chk(rd[7], 1, "flag kept");
    apb(1, 12'h000, 32'h58);
    apb(0, 12'h000, 0);
    chk(rd[7], 0, "cleared");
    repeat (2) @(posedge pclk);
    chk(ovf_irq, 0, "irq drop");
    $display("End overflow test");
    stop_test;
  end
  // Cut a hung run
  initial begin
    #400000;
    err_count++;
    stop_test;
  end
endmodule
bind tsc_top tsc_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .ovf_irq, .up_down_mode, .coherency_restart);
